//--- pia_params.svh
`ifndef PIA_PARAMS_SVH
`define PIA_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets (word index on the peripheral bus)
// ---------------------------------------------------------------
`define PIA_OFS_PRIO0      5'h00
`define PIA_PRIO_REGS      10
`define PIA_OFS_VBASE      5'h0A
`define PIA_OFS_FM0        5'h0B
`define PIA_OFS_FVL0       5'h0C
`define PIA_OFS_FVH0       5'h0D
`define PIA_OFS_FM1        5'h0E
`define PIA_OFS_FVL1       5'h0F
`define PIA_OFS_FVH1       5'h10
`define PIA_OFS_PEND0      5'h11
`define PIA_PEND_REGS      6
`define PIA_OFS_CTRL       5'h1D

// ---------------------------------------------------------------
// field layout and sizes
// ---------------------------------------------------------------
`define PIA_NUM_SRC        82
`define PIA_FIXED_SRC      2
`define PIA_FIELDS_PER_REG 8
`define PIA_CTRL_DIS_BIT   5
`define PIA_FAST_LEVEL     2'h2
`define PIA_FIXED_LEVEL    2'h3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PIA_RST_REG        16'h0000
`define PIA_RESET_ADDR     21'h000000

`endif

//--- pia_pkg.sv
package pia_pkg;
  typedef logic [1:0]  pia_prio_t;
  typedef logic [6:0]  pia_vec_t;
  typedef logic [15:0] pia_word_t;
  typedef logic [20:0] pia_addr_t;
  typedef enum logic {PIA_BOOT, PIA_RUN} pia_phase_e;
endpackage

//--- pia_sel_if.sv
interface pia_sel_if;
  import pia_pkg::*;
  logic [3:0][81:0] act;
  logic             valid;
  pia_vec_t         idx;
  pia_prio_t        prio;
  modport arb (input act, output valid, idx, prio);
  modport top (output act, input valid, idx, prio);
endinterface

//--- pia_arbiter.sv
module pia_arbiter
  import pia_pkg::*;
(
  pia_sel_if.arb sel
);
  logic [3:0] hit;
  pia_vec_t   first [4];

  // ---------------------------------------------------------------
  // lowest index per level
  // ---------------------------------------------------------------
  for (genvar p = 0; p < 4; p++) begin : g_lvl
    pia_vec_t f;
    always_comb begin
      f = 7'h00;
      for (int i = 81; i >= 0; i--) begin
        if (sel.act[p][i]) begin
          f = 7'(i);
        end
      end
    end
    assign first[p] = f;
    assign hit[p]   = |sel.act[p];
  end

  // ---------------------------------------------------------------
  // highest level wins
  // ---------------------------------------------------------------
  assign sel.valid = |hit;
  assign sel.prio  = hit[3] ? 2'h3 : hit[2] ? 2'h2 : hit[1] ? 2'h1 : 2'h0;
  assign sel.idx   = first[sel.prio];
endmodule

//--- pia_top.sv
// How it works
// - Each of 82 request inputs gets priority 0, 1 or 2, or is disabled, from software, except the fixed-level sources.
// - Within a level the active request with the lowest source index wins, index 0 first and 81 last.
// - The chosen request raises a pending flag to the core with the address where its service starts.
// - A normal vector address is the vector base joined with the seven-bit vector number.
// - Configuration registers are read and written by the bus master over the peripheral bus.
// - Two fast channels, each with its own match value and vector address, are programmable on their own.
// - A pending request during wait or stop raises a wake request to the system integration unit.
// - After reset release the initial fetch address is driven on the core address output.
// - A level 2 request whose number matches a fast match value takes that channel's stored address.
// - In wait or stop only requests enabled before entry may wake the core.
// - The level code reads 00 for none, 01 for priority 0, 10 for priority 1, 11 for priority 2 or 3.
`include "pia_params.svh"

module pia_top
  import pia_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [81:0] irq_req,
  input  wire logic [1:0]  core_irq_mask,
  input  wire logic        low_power_mode,
  input  wire logic [4:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output pia_word_t        bus_rdata_ff,
  output logic             irq_pending_ff,
  output pia_addr_t        core_addr_ff,
  output logic             reset_fetch_ff,
  output logic             fast_irq_ff,
  output pia_prio_t        current_level_code_ff,
  output logic             wake_request_ff
);
  pia_sel_if sel ();

  pia_word_t   prio_reg_ff [`PIA_PRIO_REGS];
  pia_word_t   vector_base_ff;
  pia_word_t   fast_match_value_ff [2];
  pia_word_t   fast_vector_low_ff  [2];
  pia_word_t   fast_vector_high_ff [2];
  pia_word_t   ctrl_ff;
  logic [81:0] wake_en_ff;
  logic        low_power_q_ff;
  pia_phase_e  phase_ff;

  logic [81:0] src_en;
  pia_word_t   nxt_bus_rdata;
  pia_addr_t   nxt_core_addr;
  pia_addr_t   normal_addr;
  logic [1:0]  fast_hit;
  logic        nxt_irq_pending;
  pia_prio_t   nxt_level_code;
  logic        wr_prio;
  logic        wr_vbase;
  logic        wr_ctrl;
  logic [1:0]  wr_fm;
  logic [1:0]  wr_fvl;
  logic [1:0]  wr_fvh;
  logic        enter_low_power;
  logic        irq_disable;
  logic        run_phase;
  logic        nxt_fast_irq;
  pia_prio_t   nxt_level_out;
  logic        nxt_wake_request;
  logic        pend_hit;
  logic [2:0]  pend_word;
  logic [95:0] pend_view;

  // ---------------------------------------------------------------
  // per-source level mapping
  // ---------------------------------------------------------------
  for (genvar i = 0; i < `PIA_NUM_SRC; i++) begin : g_src
    pia_prio_t code;
    if (i < `PIA_FIXED_SRC) begin : g_fixed
      // fixed sources bypass the level fields and always sit at the top
      assign code = `PIA_FIXED_LEVEL;
      assign sel.act[3][i] = irq_req[i];
      assign sel.act[2][i] = 1'b0;
      assign sel.act[1][i] = 1'b0;
      assign sel.act[0][i] = 1'b0;
    end else begin : g_prog
      localparam int J = i - `PIA_FIXED_SRC;
      localparam int R = J / `PIA_FIELDS_PER_REG;
      localparam int B = (J % `PIA_FIELDS_PER_REG) * 2;
      // code 00 disables, 01..11 map to priority 0..2
      assign code = prio_reg_ff[R][B+1:B];
      assign sel.act[3][i] = 1'b0;
      assign sel.act[2][i] = irq_req[i] && (code == 2'h3);
      assign sel.act[1][i] = irq_req[i] && (code == 2'h2);
      assign sel.act[0][i] = irq_req[i] && (code == 2'h1);
    end
    assign src_en[i] = (code != 2'h0);
  end

  pia_arbiter u_arb (
    .sel (sel)
  );

  // ---------------------------------------------------------------
  // vector and level selection
  // ---------------------------------------------------------------
  assign irq_disable = ctrl_ff[`PIA_CTRL_DIS_BIT];
  // fixed-level sources report as priority 3, the rest as code minus one
  assign normal_addr = {vector_base_ff[13:0], sel.idx};
  for (genvar c = 0; c < 2; c++) begin : g_fast
    assign fast_hit[c] = sel.valid && (sel.prio == `PIA_FAST_LEVEL)
                         && (sel.idx == fast_match_value_ff[c][6:0]);
  end
  assign nxt_core_addr = (phase_ff == PIA_BOOT) ? `PIA_RESET_ADDR :
                         fast_hit[0] ? {fast_vector_high_ff[0][4:0], fast_vector_low_ff[0]} :
                         fast_hit[1] ? {fast_vector_high_ff[1][4:0], fast_vector_low_ff[1]} :
                         normal_addr;
  // core mask m permits priorities m and above
  assign nxt_irq_pending = sel.valid && !irq_disable && (sel.prio >= core_irq_mask);
  assign nxt_level_code  = !nxt_irq_pending ? 2'h0 :
                           (sel.prio == 2'h0) ? 2'h1 :
                           (sel.prio == 2'h1) ? 2'h2 : 2'h3;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign wr_prio  = bus_wr && (bus_addr < 5'(`PIA_PRIO_REGS));
  assign wr_vbase = bus_wr && (bus_addr == `PIA_OFS_VBASE);
  assign wr_ctrl  = bus_wr && (bus_addr == `PIA_OFS_CTRL);
  for (genvar c = 0; c < 2; c++) begin : g_fast_wr
    localparam logic [4:0] FM_OFS  = (c == 0) ? `PIA_OFS_FM0  : `PIA_OFS_FM1;
    localparam logic [4:0] FVL_OFS = (c == 0) ? `PIA_OFS_FVL0 : `PIA_OFS_FVL1;
    localparam logic [4:0] FVH_OFS = (c == 0) ? `PIA_OFS_FVH0 : `PIA_OFS_FVH1;
    assign wr_fm[c]  = bus_wr && (bus_addr == FM_OFS);
    assign wr_fvl[c] = bus_wr && (bus_addr == FVL_OFS);
    assign wr_fvh[c] = bus_wr && (bus_addr == FVH_OFS);
  end

  // pending view: raw request lines, 16 sources per word
  assign pend_hit  = (bus_addr >= `PIA_OFS_PEND0) && (bus_addr < `PIA_OFS_PEND0 + 5'(`PIA_PEND_REGS));
  assign pend_word = 3'(bus_addr - `PIA_OFS_PEND0);
  assign pend_view = {14'h0000, irq_req} >> {pend_word, 4'h0};

  always_comb begin
    nxt_bus_rdata = 16'h0000;
    if (bus_addr < 5'(`PIA_PRIO_REGS)) begin
      nxt_bus_rdata = prio_reg_ff[bus_addr[3:0]];
    end else if (pend_hit) begin
      nxt_bus_rdata = pend_view[15:0];
    end else begin
      unique case (bus_addr)
        `PIA_OFS_VBASE: nxt_bus_rdata = vector_base_ff;
        `PIA_OFS_FM0:   nxt_bus_rdata = fast_match_value_ff[0];
        `PIA_OFS_FVL0:  nxt_bus_rdata = fast_vector_low_ff[0];
        `PIA_OFS_FVH0:  nxt_bus_rdata = fast_vector_high_ff[0];
        `PIA_OFS_FM1:   nxt_bus_rdata = fast_match_value_ff[1];
        `PIA_OFS_FVL1:  nxt_bus_rdata = fast_vector_low_ff[1];
        `PIA_OFS_FVH1:  nxt_bus_rdata = fast_vector_high_ff[1];
        `PIA_OFS_CTRL:  nxt_bus_rdata = {ctrl_ff[15:2], current_level_code_ff};
        default:        nxt_bus_rdata = 16'h0000;
      endcase
    end
    if (!bus_rd) begin
      nxt_bus_rdata = 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < `PIA_PRIO_REGS; k++) prio_reg_ff[k] <= `PIA_RST_REG;
      vector_base_ff <= `PIA_RST_REG;
      ctrl_ff        <= `PIA_RST_REG;
      for (int c = 0; c < 2; c++) begin
        fast_match_value_ff[c] <= `PIA_RST_REG;
        fast_vector_low_ff[c]  <= `PIA_RST_REG;
        fast_vector_high_ff[c] <= `PIA_RST_REG;
      end
      bus_rdata_ff <= `PIA_RST_REG;
    end else begin
      if (wr_prio) prio_reg_ff[bus_addr[3:0]] <= bus_wdata;
      if (wr_vbase) vector_base_ff <= bus_wdata;
      if (wr_ctrl) ctrl_ff <= {10'h000, bus_wdata[5:2], 2'h0};
      for (int c = 0; c < 2; c++) begin
        if (wr_fm[c])  fast_match_value_ff[c] <= {9'h000, bus_wdata[6:0]};
        if (wr_fvl[c]) fast_vector_low_ff[c]  <= bus_wdata;
        if (wr_fvh[c]) fast_vector_high_ff[c] <= {11'h000, bus_wdata[4:0]};
      end
      bus_rdata_ff <= nxt_bus_rdata;
    end
  end

  // ---------------------------------------------------------------
  // core side and wake
  // ---------------------------------------------------------------
  assign enter_low_power = low_power_mode && !low_power_q_ff;
  // nothing reaches the core until the reset address has been shown
  assign run_phase        = (phase_ff == PIA_RUN);
  assign nxt_fast_irq     = nxt_irq_pending && run_phase && |fast_hit;
  assign nxt_level_out    = run_phase ? nxt_level_code : 2'h0;
  assign nxt_wake_request = low_power_q_ff && |(irq_req & wake_en_ff);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_ff              <= PIA_BOOT;
      irq_pending_ff        <= 1'b0;
      core_addr_ff          <= `PIA_RESET_ADDR;
      reset_fetch_ff        <= 1'b0;
      fast_irq_ff           <= 1'b0;
      current_level_code_ff <= 2'h0;
      low_power_q_ff        <= 1'b0;
      wake_en_ff            <= '0;
      wake_request_ff       <= 1'b0;
    end else begin
      // one boot cycle holds the reset address before vectors appear
      phase_ff              <= PIA_RUN;
      reset_fetch_ff        <= (phase_ff == PIA_BOOT);
      core_addr_ff          <= nxt_core_addr;
      irq_pending_ff        <= nxt_irq_pending && run_phase;
      fast_irq_ff           <= nxt_fast_irq;
      current_level_code_ff <= nxt_level_out;
      low_power_q_ff        <= low_power_mode;
      // enable set frozen at entry; later writes cannot arm a wake
      if (enter_low_power) wake_en_ff <= src_en;
      wake_request_ff       <= nxt_wake_request;
    end
  end
endmodule

//--- pia_top_asserts.sv
module pia_top_asserts
  import pia_pkg::*;
(
  input logic        sys_clk,
  input logic        rst,
  input logic [81:0] irq_req,
  input logic [1:0]  core_irq_mask,
  input logic        low_power_mode,
  input logic [4:0]  bus_addr,
  input logic [15:0] bus_wdata,
  input logic        bus_wr,
  input logic        bus_rd,
  input pia_word_t   bus_rdata_ff,
  input logic        irq_pending_ff,
  input pia_addr_t   core_addr_ff,
  input logic        reset_fetch_ff,
  input logic        fast_irq_ff,
  input pia_prio_t   current_level_code_ff,
  input logic        wake_request_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [81:0] prev_req_ff;
  always_ff @(posedge sys_clk) prev_req_ff <= irq_req;
  sequence boot_edge; reset_fetch_ff; endsequence
  sequence read_idle; !bus_rd; endsequence
  boot_addr_a: assert property (boot_edge |-> core_addr_ff == 21'h000000 && !irq_pending_ff)
    else $error("boot address wrong");
  boot_pulse_a: assert property (boot_edge |=> !reset_fetch_ff)
    else $error("boot marker too long");
  read_zero_a: assert property (read_idle |=> bus_rdata_ff == 16'h0000)
    else $error("read data without read");
  idle_level_a: assert property (!(|irq_req) |=> !irq_pending_ff && current_level_code_ff == 2'h0)
    else $error("pending without request");
  // index must name a line that was really active
  vec_src_a: assert property (irq_pending_ff && !fast_irq_ff |-> prev_req_ff[core_addr_ff[6:0]])
    else $error("vector names idle source");
  fixed_src_a: assert property (irq_req[0] && !reset_fetch_ff && !$past(rst) |=>
    irq_pending_ff && current_level_code_ff == 2'h3 && core_addr_ff[6:0] == 7'h00)
    else $error("source zero lost");
  fast_lvl_a: assert property (fast_irq_ff |-> irq_pending_ff && current_level_code_ff == 2'h3)
    else $error("fast outside level two");
  mask_lvl_a: assert property (irq_pending_ff && current_level_code_ff == 2'h1 |->
    $past(core_irq_mask) == 2'h0)
    else $error("masked request signalled");
  wake_gate_a: assert property (!low_power_mode [*2] |=> !wake_request_ff)
    else $error("wake outside low power");
endmodule

bind pia_top pia_top_asserts chk (.*);

//--- pia_core_model.sv
module pia_core_model
(
  input  logic       sys_clk,
  input  logic       rst,
  input  logic [1:0] mask_set,
  output logic [1:0] core_irq_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] mask_ff = 2'h0;
  // core moves its mask off the sampling edge, like its status register
  always @(negedge sys_clk or posedge rst)
    if (rst) mask_ff <= 2'h0;
    else mask_ff <= mask_set;
  assign core_irq_mask = mask_ff;
endmodule

//--- test_priority_interrupt_arbiter.sv
module test_priority_interrupt_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  import pia_pkg::*;
  logic sys_clk, rst, low_power_mode, bus_wr, bus_rd, irq_pending_ff, reset_fetch_ff, fast_irq_ff, wake_request_ff;
  logic [81:0] irq_req;
  logic [1:0] mask_set, core_irq_mask;
  logic [4:0] bus_addr;
  logic [15:0] bus_wdata;
  pia_word_t bus_rdata_ff;
  pia_addr_t core_addr_ff;
  pia_prio_t current_level_code_ff;
  int error_cnt = 0;
  int num_checks = 0;
  localparam logic [13:0] VB = 14'h2A5C;

  pia_top dut (.*);
  pia_core_model core (.sys_clk(sys_clk), .rst(rst), .mask_set(mask_set), .core_irq_mask(core_irq_mask));

  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ----
  // bus and check helpers
  // ----
  task automatic chk(logic [20:0] seen, logic [20:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // idle cycle after each strobe so back to back calls never retoggle it
  task automatic wr(logic [4:0] a, logic [15:0] d);
    bus_addr = a; bus_wdata = d; bus_wr = 1; cyc(1); bus_wr = 0; cyc(1);
  endtask
  task automatic rd(logic [4:0] a, logic [15:0] exp);
    bus_addr = a; bus_rd = 1; cyc(1); bus_rd = 0;
    chk(bus_rdata_ff, exp);
    cyc(1);
  endtask
  task automatic fire(logic [81:0] r, logic p, pia_addr_t a, pia_prio_t l, logic f);
    irq_req = r; cyc(1);
    chk(irq_pending_ff, p);
    if (p) begin
      chk(core_addr_ff, a);
      chk(current_level_code_ff, l);
      chk(fast_irq_ff, f);
    end
    irq_req = '0; cyc(1);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    cyc(10); rst = 0; cyc(1);
    chk(reset_fetch_ff, 1);
    chk(core_addr_ff, 0);
    cyc(1);
    chk(reset_fetch_ff, 0);
    $display("reset test done");
  endtask
  task automatic t_regs;
    wr(5'h0A, {2'h0, VB}); rd(5'h0A, {2'h0, VB});
    wr(5'h0C, 16'h1234); rd(5'h0C, 16'h1234);
    wr(5'h18, 16'hFFFF); rd(5'h18, 16'h0000);
    $display("register test done");
  endtask
  task automatic t_levels;
    for (int f = 1; f < 4; f++) begin
      wr(5'h00, 16'(f << 6));
      fire(82'h20, 1, {VB, 7'd5}, 2'(f), 0);
    end
    mask_set = 2'h1; wr(5'h00, 16'h0040);
    fire(82'h20, 0, 0, 0, 0);
    mask_set = 2'h0; cyc(1);
    $display("level test done");
  endtask
  task automatic t_order;
    wr(5'h00, 16'h4040); wr(5'h09, 16'h4000);
    fire((82'h1 << 81) | 82'h220, 1, {VB, 7'd5}, 2'h1, 0);
    fire(82'h1 << 81, 1, {VB, 7'd81}, 2'h1, 0);
    fire((82'h1 << 81) | 82'h1, 1, {VB, 7'd0}, 2'h3, 0);
    $display("order test done");
  endtask
  task automatic t_wake;
    wr(5'h00, 16'h0040); low_power_mode = 1; cyc(1);
    wr(5'h00, 16'h4040); irq_req = 82'h200; cyc(3);
    chk(wake_request_ff, 0);
    irq_req = 82'h20; cyc(2);
    chk(wake_request_ff, 1);
    low_power_mode = 0; irq_req = '0; cyc(3);
    chk(wake_request_ff, 0);
    $display("wake test done");
  endtask
  task automatic t_fast;
    wr(5'h00, 16'hC0C0); wr(5'h0B, 16'h0005); wr(5'h0D, 16'h0015);
    wr(5'h0E, 16'h0009); wr(5'h0F, 16'hABCD); wr(5'h10, 16'h000A);
    fire(82'h20, 1, 21'h151234, 2'h3, 1);
    fire(82'h200, 1, 21'h0AABCD, 2'h3, 1);
    wr(5'h0B, 16'h0006);
    fire(82'h20, 1, {VB, 7'd5}, 2'h3, 0);
    $display("fast test done");
  endtask
  task automatic t_ctrl;
    wr(5'h00, 16'h4040); irq_req = (82'h1 << 81) | 82'h220;
    rd(5'h11, 16'h0220);
    rd(5'h16, 16'h0002);
    rd(5'h1D, 16'h0001);
    wr(5'h1D, 16'h0020);
    chk(irq_pending_ff, 0);
    rd(5'h1D, 16'h0020);
    wr(5'h1D, 16'h0000);
    chk(irq_pending_ff, 1);
    irq_req = '0; wr(5'h00, 16'h00C0); mask_set = 2'h3; cyc(1);
    fire(82'h20, 0, 0, 0, 0);
    fire(82'h22, 1, {VB, 7'd1}, 2'h3, 0);
    mask_set = 2'h0; cyc(1);
    $display("control test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rst = 1; irq_req = '0; mask_set = 0; low_power_mode = 0;
    bus_addr = 0; bus_wdata = 0; bus_wr = 0; bus_rd = 0;
    t_reset; t_regs; t_levels; t_order; t_wake; t_fast; t_ctrl;
    tally_and_finish;
  end
  initial begin
    cyc(2000); error_cnt++;
    tally_and_finish;
  end
endmodule
